// >>> verilog/serial_defs.vh
`ifndef SERIAL_DEFS_VH
`define SERIAL_DEFS_VH

// transmit and receive sequencer states
`define ST_IDLE        3'h0
`define ST_START       3'h1
`define ST_DATA        3'h2
`define ST_NINTH       3'h3
`define ST_STOP        3'h4

// match scheme encodings
`define MATCH_ALL_ADDR 2'h1
`define MATCH_ADDR_DAT 2'h2
`define MATCH_DAT_ONLY 2'h3

// character layout
`define DATA_BITS      4'h8
`define LAST_BIT       3'h7
`define OVERSAMPLE     4'hf
`define MID_SAMPLE     4'h7

// line driver guard after the last stop bit, in 16x oversample ticks
`define DRIVER_HOLD    4'h1

`endif

// >>> verilog/skid_buffer.v
`timescale 1ns/1ps
// two-entry buffer; keeps one word in reserve so a stall loses nothing
module skid_buffer #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             reset_n,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:1];
  reg             wr_ptr_q;
  reg             rd_ptr_q;
  reg [1:0]       count_q;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data  = mem_q[rd_ptr_q];

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'h0;
      mem_q[0] <= {WIDTH{1'b0}};
      mem_q[1] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data;
        wr_ptr_q        <= ~wr_ptr_q;
      end
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      if (push && !pop)
        count_q <= count_q + 2'h1;
      else if (pop && !push)
        count_q <= count_q - 2'h1;
    end
  end
endmodule // skid_buffer

// >>> verilog/async_serial_transceiver.v
`timescale 1ns/1ps
`include "serial_defs.vh"
// Functional notes
// - eight data bits per character, least significant bit first.
// - one low start bit, then one or two high stop bits.
// - optional parity generated on transmit, checked on receive, even or odd.
// - transmitter and receiver independent, sharing baud rate and format.
// - separate transmit and receive enables gate each direction.
// - tx_holding_empty is 1 when a new byte may be written.
// - written byte moves to the shift register and is sent automatically.
// - transmit interrupt shows holding register free, at once when enabled.
// - rx_byte_available is 1 while a received byte waits unread.
// - in multidrop mode the ninth bit follows ninth_bit_tx_select.
// - clear_to_send_gate decides whether clear-to-send may hold off sending.
// - multidrop_on adds the ninth bit and enables match receive logic.
// - 16-bit baud divider, also usable as a timer when serial idle.
// - receiver flags framing, parity, overrun and break.
// - separate transmit and receive interrupt requests.
// - line_driver_on asserted around own transmissions.
// - ninth bit sits after data bits and before stop bits.
// - clear-to-send sampled before a character starts; current one finishes.
// - match scheme 01 all addresses, 10 matched address+data, 11 data only.
module async_serial_transceiver #(
  parameter DIV_WIDTH = 16
) (
  // clock and reset
  input  wire                 core_clk,
  input  wire                 reset_n,
  // configuration
  input  wire [DIV_WIDTH-1:0] baud_divider,
  input  wire                 timer_mode,
  input  wire                 tx_on,
  input  wire                 rx_on,
  input  wire                 parity_on,
  input  wire                 parity_odd,
  input  wire                 two_stop_bits,
  input  wire                 clear_to_send_gate,
  input  wire                 multidrop_on,
  input  wire [1:0]           multidrop_match_scheme,
  input  wire [7:0]           node_address,
  input  wire                 ninth_bit_tx_select,
  input  wire                 tx_irq_on,
  input  wire                 rx_irq_on,
  // transmit data write
  input  wire                 tx_write,
  input  wire [7:0]           tx_data,
  // receive data read
  input  wire                 rx_read,
  output reg  [7:0]           rx_data,
  output reg                  rx_ninth_bit,
  output reg                  rx_new_frame,
  // status
  output reg                  tx_holding_empty,
  output reg                  tx_idle,
  output reg                  rx_byte_available,
  output reg                  framing_error,
  output reg                  parity_error,
  output reg                  overrun_error,
  output reg                  break_seen,
  output reg                  timer_tick,
  // interrupts
  output reg                  tx_irq,
  output reg                  rx_irq,
  // serial pins
  input  wire                 rxd,
  input  wire                 clear_to_send_n,
  output reg                  txd,
  output reg                  line_driver_on
);
  // baud divider: one 16x oversample tick per reload
  reg [DIV_WIDTH-1:0] div_q;
  wire tick = (div_q == {DIV_WIDTH{1'b0}});
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q      <= {DIV_WIDTH{1'b0}};
      timer_tick <= 1'b0;
    end else begin
      div_q      <= tick ? baud_divider : div_q - 1'b1;
      timer_tick <= tick && timer_mode;
    end
  end

  // holding buffer between the write port and the transmitter
  wire       hb_ready;
  wire       hb_valid;
  wire [8:0] hb_data;
  reg        tx_take;
  skid_buffer #(.WIDTH(9)) u_hold (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .in_valid  (tx_write),
    .in_ready  (hb_ready),
    .in_data   ({ninth_bit_tx_select, tx_data}),
    .out_valid (hb_valid),
    .out_ready (tx_take),
    .out_data  (hb_data)
  );

  // transmitter; bits last 16 ticks
  reg [2:0] tx_st_q;
  reg [3:0] tx_sub_q;
  reg [2:0] tx_bit_q;
  reg [8:0] tx_sh_q;
  reg       tx_par_q;
  reg       tx_stop2_q;
  reg [3:0] hold_q;
  wire      tx_bit_end = tick && (tx_sub_q == `OVERSAMPLE);
  wire      cts_ok = !clear_to_send_gate || !clear_to_send_n;

  always @* begin
    // cts sampled on the cycle the character is taken; later changes do not stop it
    tx_take = (tx_st_q == `ST_IDLE) && hb_valid && tx_on && cts_ok && tick;
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_st_q    <= `ST_IDLE;
      tx_sub_q   <= 4'h0;
      tx_bit_q   <= 3'h0;
      tx_sh_q    <= 9'h000;
      tx_par_q   <= 1'b0;
      tx_stop2_q <= 1'b0;
      hold_q     <= 4'h0;
      txd        <= 1'b1;
      line_driver_on <= 1'b0;
    end else begin
      if (tick && tx_st_q != `ST_IDLE)
        tx_sub_q <= tx_sub_q + 4'h1;
      case (tx_st_q)
        `ST_IDLE: begin
          txd <= 1'b1;
          if (tx_take) begin
            tx_sh_q    <= hb_data;
            tx_par_q   <= parity_odd;
            tx_stop2_q <= two_stop_bits;
            tx_sub_q   <= 4'h0;
            tx_bit_q   <= 3'h0;
            txd        <= 1'b0;
            tx_st_q    <= `ST_START;
          end
        end
        `ST_START:
          if (tx_bit_end) begin
            txd     <= tx_sh_q[0];
            tx_par_q <= tx_par_q ^ tx_sh_q[0];
            tx_st_q <= `ST_DATA;
          end
        `ST_DATA:
          if (tx_bit_end) begin
            if (tx_bit_q == `LAST_BIT) begin
              if (multidrop_on) begin
                txd     <= tx_sh_q[8];
                tx_st_q <= `ST_NINTH;
              end else if (parity_on) begin
                txd     <= tx_par_q;
                tx_st_q <= `ST_NINTH;
              end else begin
                txd     <= 1'b1;
                tx_st_q <= `ST_STOP;
              end
            end else begin
              tx_sh_q  <= {tx_sh_q[8], 1'b0, tx_sh_q[7:1]};
              tx_bit_q <= tx_bit_q + 3'h1;
              txd      <= tx_sh_q[1];
              tx_par_q <= tx_par_q ^ tx_sh_q[1];
            end
          end
        `ST_NINTH:
          if (tx_bit_end) begin
            txd     <= 1'b1;
            tx_st_q <= `ST_STOP;
          end
        `ST_STOP:
          if (tx_bit_end) begin
            if (tx_stop2_q)
              tx_stop2_q <= 1'b0;
            else
              tx_st_q <= `ST_IDLE;
          end
        default: tx_st_q <= `ST_IDLE;
      endcase
      // driver stays on from the start bit until a guard tick after the stop
      if (tx_take)
        hold_q <= `DRIVER_HOLD;
      else if (tx_st_q == `ST_IDLE && tick && hold_q != 4'h0)
        hold_q <= hold_q - 4'h1;
      line_driver_on <= tx_take || (tx_st_q != `ST_IDLE) || (hold_q != 4'h0);
    end
  end

  // receiver: 16x oversampled, sampled at the bit centre
  reg [2:0] rx_st_q;
  reg [3:0] rx_sub_q;
  reg [2:0] rx_bit_q;
  reg [7:0] rx_sh_q;
  reg       rx_par_q;
  reg       rx_all_zero_q;
  reg       rx_matched_q;
  reg       rx_first_q;
  wire      rx_mid = tick && (rx_sub_q == `MID_SAMPLE);

  // decides if a finished character is delivered under the match scheme
  function deliver;
    input       mp_on;
    input [1:0] scheme;
    input       is_addr;
    input       hit;
    input       matched;
    begin
      if (!mp_on)
        deliver = 1'b1;
      else
        case (scheme)
          `MATCH_ALL_ADDR: deliver = is_addr;
          `MATCH_ADDR_DAT: deliver = is_addr ? hit : matched;
          `MATCH_DAT_ONLY: deliver = !is_addr && matched;
          default:         deliver = 1'b1;
        endcase
    end
  endfunction

  reg       rx_ninth_q;
  wire      rx_has_ninth = multidrop_on || parity_on;
  wire      rx_hit = (rx_sh_q == node_address);
  wire      rx_dlv = deliver(multidrop_on, multidrop_match_scheme, rx_ninth_q, rx_hit,
                             rx_matched_q);

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_st_q <= `ST_IDLE;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_par_q <= 1'b0;
      rx_ninth_q <= 1'b0;
      rx_all_zero_q <= 1'b0;
      rx_matched_q <= 1'b0;
      rx_first_q <= 1'b0;
      rx_data <= 8'h00;
      rx_ninth_bit <= 1'b0;
      rx_new_frame <= 1'b0;
      rx_byte_available <= 1'b0;
      framing_error <= 1'b0;
      parity_error <= 1'b0;
      overrun_error <= 1'b0;
      break_seen <= 1'b0;
    end else begin
      if (rx_read) begin
        rx_byte_available <= 1'b0;
        framing_error <= 1'b0;
        parity_error <= 1'b0;
        overrun_error <= 1'b0;
        break_seen <= 1'b0;
      end
      if (tick)
        rx_sub_q <= rx_sub_q + 4'h1;
      case (rx_st_q)
        `ST_IDLE: begin
          rx_sub_q <= 4'h0;
          if (tick && !rxd && rx_on)
            rx_st_q <= `ST_START;
        end
        `ST_START:
          if (rx_mid) begin
            rx_st_q  <= rxd ? `ST_IDLE : `ST_DATA; // glitch rejects
            rx_bit_q <= 3'h0;
            rx_par_q <= parity_odd;
            rx_all_zero_q <= 1'b1;
          end
        `ST_DATA:
          if (rx_mid) begin
            rx_sh_q  <= {rxd, rx_sh_q[7:1]};
            rx_par_q <= rx_par_q ^ rxd;
            rx_all_zero_q <= rx_all_zero_q && !rxd;
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == `LAST_BIT)
              rx_st_q <= rx_has_ninth ? `ST_NINTH : `ST_STOP;
          end
        `ST_NINTH:
          if (rx_mid) begin
            rx_ninth_q <= rxd;
            rx_par_q <= rx_par_q ^ rxd;
            rx_all_zero_q <= rx_all_zero_q && !rxd;
            rx_st_q <= `ST_STOP;
          end
        `ST_STOP:
          if (rx_mid) begin
            rx_st_q <= `ST_IDLE;
            if (!multidrop_on)
              rx_ninth_q <= 1'b0;
            if (multidrop_on && rx_ninth_q) begin
              rx_matched_q <= rx_hit;
              rx_first_q   <= 1'b1;
            end
            if (rx_dlv) begin
              // set wins over a read in the same cycle
              if (rx_byte_available && !rx_read)
                overrun_error <= 1'b1;
              else
                rx_data <= rx_sh_q;
              rx_byte_available <= 1'b1;
              rx_ninth_bit <= rx_ninth_q;
              rx_new_frame <= multidrop_on && !rx_ninth_q && rx_first_q;
              if (multidrop_on && !rx_ninth_q)
                rx_first_q <= 1'b0;
              framing_error <= !rxd;
              parity_error <= parity_on && !multidrop_on && rx_par_q;
              break_seen <= rx_all_zero_q && !rxd;
            end
          end
        default: rx_st_q <= `ST_IDLE;
      endcase
    end
  end

  // status and interrupt outputs, all registered
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_holding_empty <= 1'b1;
      tx_idle <= 1'b1;
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      tx_holding_empty <= hb_ready && !(tx_write && !tx_take && hb_valid);
      tx_idle <= (tx_st_q == `ST_IDLE) && !hb_valid;
      tx_irq <= tx_irq_on && hb_ready;
      rx_irq <= rx_irq_on && (rx_byte_available || framing_error || break_seen);
    end
  end

  // tx and rx sequencers share only the tick and format inputs
endmodule // async_serial_transceiver

// >>> testbench/serial_checker.sv
`timescale 1ns/1ps
module serial_checker (
  input wire       core_clk,
  input wire       reset_n,
  input wire       tx_on,
  input wire       tx_irq_on,
  input wire       rx_irq_on,
  input wire       clear_to_send_gate,
  input wire       clear_to_send_n,
  input wire [7:0] rx_data,
  input wire       tx_holding_empty,
  input wire       tx_idle,
  input wire       rx_byte_available,
  input wire       overrun_error,
  input wire       tx_irq,
  input wire       rx_irq,
  input wire       txd,
  input wire       line_driver_on
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence start_low;
    (!txd) [*8];
  endsequence
  // the start decision reads gate and pin in the cycle it would launch the start bit
  sequence held_off;
    clear_to_send_gate && clear_to_send_n && !line_driver_on;
  endsequence
  a_start_bit_low: assert property ($fell(txd) |-> start_low)
    else $error("start bit shorter than expected");
  a_line_idle_high: assert property (!line_driver_on |-> txd)
    else $error("txd low while driver off");
  a_driver_at_start: assert property ($fell(txd) |-> line_driver_on)
    else $error("start bit without driver enable");
  a_tx_off_holds: assert property (!tx_on && !line_driver_on |=> !line_driver_on)
    else $error("transmit started while disabled");
  a_cts_holds_off: assert property (held_off |=> !line_driver_on)
    else $error("transmit started while held off");
  a_idle_is_empty: assert property (tx_idle |-> tx_holding_empty)
    else $error("idle transmitter reports full holding buffer");
  a_tx_irq_prompt: assert property (tx_irq_on && tx_holding_empty |-> ##[0:2] tx_irq)
    else $error("transmit interrupt missing");
  a_rx_irq_prompt: assert property (rx_irq_on && rx_byte_available |-> ##[0:2] rx_irq)
    else $error("receive interrupt missing");
  a_overrun_keeps: assert property ($rose(overrun_error) |->
    rx_byte_available && $stable(rx_data))
    else $error("overrun lost held byte");
endmodule // serial_checker

// >>> testbench/serial_node_model.sv
`timescale 1ns/1ps
module serial_node_model #(
  parameter BIT = 32
) (
  input  wire core_clk,
  input  wire txd,
  output reg  rxd,
  output reg  clear_to_send_n
);
  initial begin
    rxd = 1'b1;
    clear_to_send_n = 1'b0;
  end
  // the node is the only driver of its own flow control pin
  task set_cts(input v);
    clear_to_send_n <= v;
  endtask
  // bits go out lsb first; the line returns to its idle high level after
  task send(input [12:0] v, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        rxd <= v[i];
        repeat (BIT) @(posedge core_clk);
      end
      rxd <= 1'b1;
    end
  endtask
  // returns at mid stop so a following start edge is not missed
  task capture(output [12:0] v, input integer n, input integer limit);
    integer i;
    begin
      v = 13'h1fff;
      i = 0;
      while (txd !== 1'b0 && i < limit) begin
        @(posedge core_clk);
        i = i + 1;
      end
      if (i < limit) begin
        repeat (BIT / 2) @(posedge core_clk);
        for (i = 0; i < n; i = i + 1) begin
          v[i] = txd;
          if (i < n - 1)
            repeat (BIT) @(posedge core_clk);
        end
      end
    end
  endtask
endmodule // serial_node_model

// >>> testbench/test_async_serial_transceiver.sv
`timescale 1ns/1ps
module test_async_serial_transceiver;
  localparam BIT = 32;
  localparam LIMIT = 20000;
  reg         core_clk = 1'b0;
  reg         reset_n = 1'b0;
  reg  [15:0] baud_divider = 16'h0001;
  reg         timer_mode = 1'b0;
  reg         tx_on = 1'b0;
  reg         rx_on = 1'b0;
  reg         parity_on = 1'b0;
  reg         parity_odd = 1'b0;
  reg         two_stop_bits = 1'b0;
  reg         clear_to_send_gate = 1'b0;
  reg         multidrop_on = 1'b0;
  reg  [1:0]  multidrop_match_scheme = 2'h0;
  reg  [7:0]  node_address = 8'h5a;
  reg         ninth_bit_tx_select = 1'b0;
  reg         tx_irq_on = 1'b0;
  reg         rx_irq_on = 1'b1;
  reg         tx_write = 1'b0;
  reg  [7:0]  tx_data = 8'h00;
  reg         rx_read = 1'b0;
  wire [7:0]  rx_data;
  wire        rx_ninth_bit, rx_new_frame, tx_holding_empty, tx_idle, rx_byte_available;
  wire        framing_error, parity_error, overrun_error, break_seen, timer_tick;
  wire        tx_irq, rx_irq, rxd, clear_to_send_n, txd, line_driver_on;
  integer     miscompares = 0;
  integer     checks_done = 0;
  integer     cycles = 0;
  integer     k;
  reg  [12:0] got;

  always #2.5 core_clk = ~core_clk;

  async_serial_transceiver i_dut (.*);
  serial_node_model #(.BIT(BIT)) i_node (.core_clk(core_clk), .txd(txd), .rxd(rxd),
    .clear_to_send_n(clear_to_send_n));

  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp, input [8*16-1:0] what);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  function [12:0] frame(input [7:0] d, input has9, input b9);
    frame = has9 ? {3'b111, b9, d, 1'b0} : {4'hf, d, 1'b0};
  endfunction
  task write_byte(input [7:0] d);
    begin
      @(posedge core_clk);
      tx_data <= d;
      tx_write <= 1'b1;
      @(posedge core_clk);
      tx_write <= 1'b0;
    end
  endtask
  task wait_idle;
    integer n;
    begin
      n = 0;
      while (tx_idle !== 1'b1 && n < 2000) begin
        @(posedge core_clk);
        n = n + 1;
      end
      repeat (BIT) @(posedge core_clk);
    end
  endtask
  task read_rx;
    begin
      @(posedge core_clk);
      rx_read <= 1'b1;
      @(posedge core_clk);
      rx_read <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task rx_frame(input [12:0] v);
    begin
      i_node.send(v, 11);
      repeat (4) @(posedge core_clk);
    end
  endtask
  task t_reset;
    begin
      repeat (5) @(posedge core_clk);
      check({txd, tx_holding_empty, tx_idle, rx_byte_available, line_driver_on}, 5'h1c, "reset");
      reset_n <= 1'b1;
      @(posedge core_clk);
      tx_irq_on <= 1'b1;
      repeat (3) @(posedge core_clk);
      check(tx_irq, 1'b1, "tx_irq");
    end
  endtask
  task t_formats;
    reg [7:0] d;
    reg       b9;
    begin
      tx_on <= 1'b1;
      for (k = 0; k < 5; k = k + 1) begin
        d = 8'h96 ^ (k[7:0] * 8'h3b);
        parity_on <= (k == 1 || k == 2);
        parity_odd <= (k == 2);
        two_stop_bits <= (k == 2 || k == 4);
        multidrop_on <= (k >= 3);
        ninth_bit_tx_select <= (k == 3);
        b9 = (k >= 3) ? (k == 3) : ((k == 2) ? ~^d : ^d);
        write_byte(d);
        i_node.capture(got, 10 + (k > 0) + (k == 2 || k == 4), 200);
        check(got, frame(d, k > 0, b9), "tx frame");
        wait_idle;
      end
    end
  endtask
  task t_flow;
    begin
      parity_on <= 1'b0;
      multidrop_on <= 1'b0;
      two_stop_bits <= 1'b0;
      tx_on <= 1'b0;
      write_byte(8'h11);
      write_byte(8'h22);
      write_byte(8'h33);
      repeat (BIT) @(posedge core_clk);
      check({tx_holding_empty, txd}, 2'b01, "full and off");
      clear_to_send_gate <= 1'b1;
      i_node.set_cts(1'b1);
      tx_on <= 1'b1;
      repeat (3 * BIT) @(posedge core_clk);
      // buffer is full, so the transmitter is not idle but must stay silent
      check({tx_idle, line_driver_on, txd}, 3'b001, "tx held off");
      i_node.set_cts(1'b0);
      i_node.capture(got, 10, 200);
      check(got, frame(8'h11, 1'b0, 1'b0), "first byte");
      i_node.capture(got, 10, BIT);
      check(got, frame(8'h22, 1'b0, 1'b0), "second byte");
      i_node.capture(got, 10, 2 * BIT);
      check(got, 13'h1fff, "dropped write");
      wait_idle;
      check(tx_holding_empty, 1'b1, "tx_holding_empty");
      clear_to_send_gate <= 1'b0;
      i_node.set_cts(1'b1);
      write_byte(8'h5c);
      i_node.capture(got, 10, 200);
      check(got, frame(8'h5c, 1'b0, 1'b0), "cts ignored");
      wait_idle;
      i_node.set_cts(1'b0);
    end
  endtask
  task t_rx;
    begin
      rx_on <= 1'b1;
      parity_on <= 1'b1;
      rx_frame(frame(8'h3c, 1'b1, 1'b0));
      check({rx_byte_available, parity_error, rx_irq, rx_data}, {3'b101, 8'h3c}, "rx byte");
      rx_frame(frame(8'hc5, 1'b1, 1'b0));
      check({overrun_error, rx_byte_available, rx_data}, {2'b11, 8'h3c}, "overrun");
      read_rx;
      check({overrun_error, rx_byte_available}, 2'b00, "after read");
      rx_frame(frame(8'h3c, 1'b1, 1'b1));
      check(parity_error, 1'b1, "parity_error");
      read_rx;
      rx_frame(frame(8'h3c, 1'b1, 1'b0) & 13'h1bff);
      check(framing_error, 1'b1, "framing_error");
      read_rx;
      rx_frame(13'h0000);
      check(break_seen, 1'b1, "break_seen");
      read_rx;
      rx_on <= 1'b0;
      rx_frame(frame(8'h81, 1'b1, 1'b0));
      check(rx_byte_available, 1'b0, "rx while off");
    end
  endtask

  task t_match;
    begin
      rx_on <= 1'b1;
      parity_on <= 1'b0;
      multidrop_on <= 1'b1;
      multidrop_match_scheme <= 2'h2;
      rx_frame(frame(8'h33, 1'b1, 1'b1));
      rx_frame(frame(8'h44, 1'b1, 1'b0));
      check(rx_byte_available, 1'b0, "other node");
      rx_frame(frame(8'h5a, 1'b1, 1'b1));
      check({rx_byte_available, rx_ninth_bit, rx_data}, {2'b11, 8'h5a}, "own address");
      read_rx;
      rx_frame(frame(8'h77, 1'b1, 1'b0));
      check({rx_byte_available, rx_new_frame, rx_data}, {2'b11, 8'h77}, "first data");
      read_rx;
      rx_frame(frame(8'h78, 1'b1, 1'b0));
      check({rx_new_frame, rx_ninth_bit, rx_data}, {2'b00, 8'h78}, "later data");
      read_rx;
      multidrop_match_scheme <= 2'h3;
      rx_frame(frame(8'h5a, 1'b1, 1'b1));
      check(rx_byte_available, 1'b0, "address hidden");
      rx_frame(frame(8'h79, 1'b1, 1'b0));
      check({rx_new_frame, rx_data}, {1'b1, 8'h79}, "data only");
      read_rx;
      multidrop_match_scheme <= 2'h1;
      rx_frame(frame(8'h33, 1'b1, 1'b1));
      check({rx_byte_available, rx_data}, {1'b1, 8'h33}, "any address");
      read_rx;
      rx_frame(frame(8'h7a, 1'b1, 1'b0));
      check(rx_byte_available, 1'b0, "data hidden");
    end
  endtask
  task t_timer;
    integer n;
    begin
      n = 0;
      timer_mode <= 1'b1;
      repeat (2) @(posedge core_clk);
      // one tick every two clocks at the bench divider setting
      repeat (2 * BIT) begin
        @(posedge core_clk);
        n = n + timer_tick;
      end
      check(n, BIT, "timer_tick");
      timer_mode <= 1'b0;
    end
  endtask

  initial begin
    t_reset;
    t_formats;
    t_flow;
    t_rx;
    t_match;
    t_timer;
    print_verdict;
  end
  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end
endmodule // test_async_serial_transceiver

bind async_serial_transceiver serial_checker i_chk (.*);
